/* File: core/sofc_defs.vh */
// constants for the serial output format control block
// assumes an apb slave with 32-bit data, one register per aligned word
`ifndef SOFC_DEFS_VH
`define SOFC_DEFS_VH

// ==========================================================
// register indexes, byte address is four times the index
`define SOFC_IDX_PAT_LO        8'h10
`define SOFC_IDX_PAT_HI        8'h12
`define SOFC_IDX_FMT_CTRL      8'h16
`define SOFC_IDX_FMT_RDBK      8'h17
`define SOFC_IDX_DRV_CTRL      8'h18
`define SOFC_IDX_DRV_RDBK      8'h19
`define SOFC_IDX_STATUS        8'h1a
`define SOFC_ADDR_LSB          2

// ==========================================================
// reset values
`define SOFC_RST_FMT           8'h00
`define SOFC_RST_DRV           8'h00
`define SOFC_RST_PAT_LO        8'h00
`define SOFC_RST_PAT_HI        4'h0

// ==========================================================
// format control fields
`define SOFC_FMT_EQ_BIT        4
`define SOFC_FMT_NUMFMT_BIT    3
`define SOFC_FMT_MSBFIRST_BIT  2
`define SOFC_FMT_PAT_HI        1
`define SOFC_FMT_PAT_LO        0

// ==========================================================
// driver control fields
`define SOFC_DRV_TERM_BIT      4
`define SOFC_DRV_CUR_HI        3
`define SOFC_DRV_CUR_LO        2
`define SOFC_DRV_CM_BIT        1
`define SOFC_DRV_SLVS_BIT      0
`define SOFC_CUR_2MA5          2'h0
`define SOFC_CUR_3MA5          2'h1
`define SOFC_CUR_RSVD          2'h2
`define SOFC_CUR_5MA           2'h3

// ==========================================================
// status fields
`define SOFC_STAT_UNDERRUN_BIT 0
`define SOFC_STAT_LEVEL_LO     1

// ==========================================================
// pattern select codes and fixed training words
`define SOFC_PAT_SAMPLES       2'h0
`define SOFC_PAT_STEP          2'h1
`define SOFC_PAT_ALT           2'h2
`define SOFC_PAT_CUSTOM        2'h3
`define SOFC_WORD_STEP         12'h03f
`define SOFC_WORD_ALT          12'haaa

`endif

/* File: core/sofc_top.v */
// serial output format control: apb registers, sample fifo and serializer
// assumes a free-running external bit clock sampled by ref_clk (40 mhz),
// bit clock well below half of ref_clk, samples arrive in two's complement
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "sofc_defs.vh"
`default_nettype none

// ==========================================================
// sample fifo
module sofc_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   // clock and reset
   input  wire             ref_clk,
   input  wire             arst_n,
   // fill side
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   // drain side
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready,
   // fill level
   output reg  [AW:0]      level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   wire            push;
   wire            pop;

   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rd_ptr];

   always @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   // one count gives full and empty, so they never disagree with each other
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         level <= {(AW+1){1'b0}};
      end else if (push & ~pop) begin
         level <= level + 1'b1;
      end else if (pop & ~push) begin
         level <= level - 1'b1;
      end
   end
endmodule // sofc_fifo

// ==========================================================
// top
// Contract
// RQ1: format control write-only, next address reads it
// RQ2: driver control write-only, next address reads it
// RQ3: software writes zero into bits 7:5
// RQ4: format bit 4 switches equalizer on
// RQ5: format bit 3 picks offset binary
// RQ6: format bit 2 sends msb first
// RQ7: pattern zero sends filtered samples
// RQ8: nonzero pattern repeats a training word
// RQ9: pattern one sends zeros then ones; code sends 12'h03f in the set bit order, so lsb first gives ones then zeros
// RQ10: pattern two sends alternating ones, zeros
// RQ11: pattern three sends the custom word
// RQ12: bit and word clocks never change
// RQ13: driver bit 0 selects slvs
// RQ14: common mode bit only in lvds
// RQ15: software sets common mode by supply
// RQ16: driver bit 4 enables termination
// RQ17: drive field sets current, 10 reserved
// RQ18: readback writes ignored, changes at word boundary
module sofc_top #(
   parameter WORD_BITS  = 12,
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW    = 5
) (
   // clock and reset
   input  wire                 ref_clk,
   input  wire                 arst_n,
   // apb slave
   input  wire                 psel,
   input  wire                 penable,
   input  wire                 pwrite,
   input  wire [7:0]           paddr,
   input  wire [31:0]          pwdata,
   output reg  [31:0]          prdata,
   output wire                 pready,
   output wire                 pslverr,
   // filtered samples
   input  wire [WORD_BITS-1:0] sample_data,
   input  wire                 sample_valid,
   output wire                 sample_ready,
   // serial link
   input  wire                 link_bit_clk,
   output reg                  ser_data,
   output reg                  bit_clk_out,
   output reg                  word_clk_out,
   // filter and driver controls
   output reg                  equalizer_on,
   output reg                  slvs_select,
   output reg                  common_mode_select,
   output reg  [1:0]           drive_current,
   output reg                  termination_on
);
   reg  [7:0]           fmt_ctrl;
   reg  [7:0]           drv_ctrl;
   reg  [7:0]           pat_lo;
   reg  [3:0]           pat_hi;
   reg                  underrun;
   reg                  rd_err;
   reg  [31:0]          next_rdata;
   reg                  next_err;
   wire [7:0]           idx;
   wire                 setup;
   wire                 wr_acc;
   wire [FIFO_AW:0]     level;
   wire [WORD_BITS-1:0] fifo_data;
   wire                 fifo_valid;
   wire                 fifo_pop;
   reg  [2:0]           bclk_sync;
   wire                 bclk_rise;
   reg  [3:0]           bit_cnt;
   reg  [WORD_BITS-1:0] shreg;
   reg                  act_msb_first;
   reg  [WORD_BITS-1:0] next_word;
   wire                 word_start;
   wire                 bit_last;
   wire [1:0]           drv_code;
   wire                 underrun_set;
   wire                 underrun_clr;

   // ==========================================================
   // apb decode: one wait-free access, read data captured in setup
   assign idx     = {2'b00, paddr[7:`SOFC_ADDR_LSB]};
   assign setup   = psel & ~penable;
   assign wr_acc  = psel & penable & pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & rd_err;

   always @* begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      case (idx)
         `SOFC_IDX_PAT_LO:   next_rdata[7:0] = pat_lo;
         `SOFC_IDX_PAT_HI:   next_rdata[3:0] = pat_hi;
         `SOFC_IDX_FMT_CTRL: next_rdata = 32'h0000_0000;
         `SOFC_IDX_FMT_RDBK: next_rdata[7:0] = fmt_ctrl;   // see RQ1
         `SOFC_IDX_DRV_CTRL: next_rdata = 32'h0000_0000;
         `SOFC_IDX_DRV_RDBK: next_rdata[7:0] = drv_ctrl;   // see RQ2
         `SOFC_IDX_STATUS: begin
            next_rdata[`SOFC_STAT_UNDERRUN_BIT] = underrun;
            next_rdata[`SOFC_STAT_LEVEL_LO +: FIFO_AW+1] = level;
         end
         default:            next_err = 1'b1;
      endcase
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
         rd_err <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0000_0000 : next_rdata;
         rd_err <= next_err;
      end
   end

   // ==========================================================
   // control registers; readback addresses take no writes
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fmt_ctrl <= `SOFC_RST_FMT;
         drv_ctrl <= `SOFC_RST_DRV;
         pat_lo   <= `SOFC_RST_PAT_LO;
         pat_hi   <= `SOFC_RST_PAT_HI;
      end else if (wr_acc) begin
         case (idx)
            `SOFC_IDX_FMT_CTRL: fmt_ctrl <= pwdata[7:0];   // see RQ1
            `SOFC_IDX_DRV_CTRL: drv_ctrl <= pwdata[7:0];   // see RQ2
            `SOFC_IDX_PAT_LO:   pat_lo   <= pwdata[7:0];
            `SOFC_IDX_PAT_HI:   pat_hi   <= pwdata[3:0];
            default: begin
               // readback and status writes fall here, see RQ18
            end
         endcase
      end
   end

   // ==========================================================
   // driver settings: static levels, no word alignment needed
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         slvs_select        <= 1'b0;
         common_mode_select <= 1'b0;
         termination_on     <= 1'b0;
      end else begin
         slvs_select        <= drv_ctrl[`SOFC_DRV_SLVS_BIT];                 // see RQ13
         // slvs has a fixed common mode, so the select is forced low there
         common_mode_select <= drv_ctrl[`SOFC_DRV_CM_BIT] &
                               ~drv_ctrl[`SOFC_DRV_SLVS_BIT];                // see RQ14
         termination_on     <= drv_ctrl[`SOFC_DRV_TERM_BIT];                 // see RQ16
      end
   end

   // ==========================================================
   // drive current; the reserved code falls back to the weakest drive
   assign drv_code = drv_ctrl[`SOFC_DRV_CUR_HI:`SOFC_DRV_CUR_LO];

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         drive_current <= `SOFC_CUR_2MA5;
      end else if (drv_code == `SOFC_CUR_RSVD) begin
         drive_current <= `SOFC_CUR_2MA5;                                    // see RQ17
      end else begin
         drive_current <= drv_code;                                          // see RQ17
      end
   end

   // ==========================================================
   // sample fifo; the serializer drains one word per word period
   sofc_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .arst_n    (arst_n),
      .in_data   (sample_data),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .level     (level)
   );

   // ==========================================================
   // link clock: two stages, third stage only for edge finding
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bclk_sync <= 3'h0;
      end else begin
         bclk_sync <= {bclk_sync[1:0], link_bit_clk};
      end
   end
   assign bclk_rise  = bclk_sync[1] & ~bclk_sync[2];
   assign word_start = bclk_rise & (bit_cnt == 4'h0);
   // samples are consumed even in training modes so the source stalls only while the fifo holds 32 words
   assign fifo_pop   = word_start;

   // ==========================================================
   // next word: pattern and format picked at the word boundary
   always @* begin
      case (fmt_ctrl[`SOFC_FMT_PAT_HI:`SOFC_FMT_PAT_LO])
         `SOFC_PAT_SAMPLES: begin
            // empty fifo sends a zero word
            next_word = fifo_valid ? fifo_data : {WORD_BITS{1'b0}};          // see RQ7
            if (fmt_ctrl[`SOFC_FMT_NUMFMT_BIT]) begin
               next_word[WORD_BITS-1] = ~next_word[WORD_BITS-1];             // see RQ5
            end
         end
         `SOFC_PAT_STEP:   next_word = `SOFC_WORD_STEP;                      // see RQ8, see RQ9
         `SOFC_PAT_ALT:    next_word = `SOFC_WORD_ALT;                       // see RQ10
         `SOFC_PAT_CUSTOM: next_word = {pat_hi, pat_lo};                     // see RQ11
         default:          next_word = {WORD_BITS{1'b0}};
      endcase
   end

   // ==========================================================
   // serializer clocks: bit and word clocks follow the link whatever the pattern
   assign bit_last = (bit_cnt == WORD_BITS - 1);

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bit_cnt      <= 4'h0;
         bit_clk_out  <= 1'b0;
         word_clk_out <= 1'b0;
      end else begin
         bit_clk_out <= bclk_sync[1];                                        // see RQ12
         if (bclk_rise) begin
            word_clk_out <= (bit_cnt < (WORD_BITS / 2));                     // see RQ12
            if (bit_last) begin
               bit_cnt <= 4'h0;
            end else begin
               bit_cnt <= bit_cnt + 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // word settings: latched at the word start so a word never mixes two formats
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         act_msb_first <= 1'b0;
         equalizer_on  <= 1'b0;
      end else if (word_start) begin
         act_msb_first <= fmt_ctrl[`SOFC_FMT_MSBFIRST_BIT];                  // see RQ18
         equalizer_on  <= fmt_ctrl[`SOFC_FMT_EQ_BIT];                        // see RQ4, see RQ18
      end
   end

   // ==========================================================
   // shifter: one bit per link clock rising edge
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shreg    <= {WORD_BITS{1'b0}};
         ser_data <= 1'b0;
      end else if (word_start) begin
         if (fmt_ctrl[`SOFC_FMT_MSBFIRST_BIT]) begin
            ser_data <= next_word[WORD_BITS-1];                              // see RQ6
            shreg    <= {next_word[WORD_BITS-2:0], 1'b0};
         end else begin
            ser_data <= next_word[0];                                        // see RQ6
            shreg    <= {1'b0, next_word[WORD_BITS-1:1]};
         end
      end else if (bclk_rise) begin
         if (act_msb_first) begin
            ser_data <= shreg[WORD_BITS-1];
            shreg    <= {shreg[WORD_BITS-2:0], 1'b0};
         end else begin
            ser_data <= shreg[0];
            shreg    <= {1'b0, shreg[WORD_BITS-1:1]};
         end
      end
   end

   // ==========================================================
   // underrun: sticky, write one to clear; a set in the same cycle wins
   assign underrun_set = word_start & ~fifo_valid &
                         (fmt_ctrl[`SOFC_FMT_PAT_HI:`SOFC_FMT_PAT_LO] == `SOFC_PAT_SAMPLES);
   assign underrun_clr = wr_acc & (idx == `SOFC_IDX_STATUS) & pwdata[`SOFC_STAT_UNDERRUN_BIT];

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         underrun <= 1'b0;
      end else if (underrun_set) begin
         underrun <= 1'b1;
      end else if (underrun_clr) begin
         underrun <= 1'b0;
      end
   end
endmodule // sofc_top

`default_nettype wire

/* File: verif/sofc_capture.sv */
// capture model of the receiving side: rebuilds words from the link
// assumes bit and word clocks arrive as ref_clk-domain registers
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// capture
module sofc_capture (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // serial link from the block
   input  wire logic        bit_clk,
   input  wire logic        word_clk,
   input  wire logic        ser_data,
   // rebuilt word, first received bit in bit 0
   output logic [11:0]      word_bits,
   output logic             word_valid
);
   logic        bclk_q, wclk_q;
   logic [11:0] sh;
   logic [3:0]  n;
   // sample at the falling bit clock, mid-bit, away from the data change
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bclk_q <= 1'b0;
         wclk_q <= 1'b0;
         sh <= 12'h000;
         n <= 4'hc;
         word_bits <= 12'h000;
         word_valid <= 1'b0;
      end else begin
         bclk_q <= bit_clk;
         word_valid <= 1'b0;
         if (bclk_q && !bit_clk) begin
            wclk_q <= word_clk;
            sh <= {ser_data, sh[11:1]};
            if (word_clk && !wclk_q) n <= 4'h1;
            else if (n < 4'hc) n <= n + 4'h1;
            if (n == 4'hb && !(word_clk && !wclk_q)) begin
               word_valid <= 1'b1;
               word_bits <= {ser_data, sh[11:1]};
            end
         end
      end
   end
endmodule // sofc_capture
`default_nettype wire

/* File: verif/sofc_top_asserts.sv */
// checker for sofc_top: readback, driver controls, link clocks
// assumes it is bound into sofc_top and sees only its ports
`timescale 1ns/1ps
`include "sofc_defs.vh"
`default_nettype none
// ==========================================================
// checker
module sofc_top_asserts (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        arst_n,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   // link and driver controls
   input wire logic        bit_clk_out,
   input wire logic        word_clk_out,
   input wire logic        slvs_select,
   input wire logic        common_mode_select,
   input wire logic [1:0]  drive_current,
   input wire logic        termination_on
);
   logic [7:0] fmt_q, drv_q, wcnt;
   logic       wseen;
   wire        acc = psel && penable && pready;
   wire  [7:0] idx = {2'b00, paddr[7:2]};
   wire        rd  = acc && !pwrite;
   // shadow of the last control write; readback writes must never land here
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fmt_q <= `SOFC_RST_FMT;
         drv_q <= `SOFC_RST_DRV;
         wcnt  <= 8'h00;
         wseen <= 1'b0;
      end else begin
         if (acc && pwrite && idx == `SOFC_IDX_FMT_CTRL) fmt_q <= pwdata[7:0];
         if (acc && pwrite && idx == `SOFC_IDX_DRV_CTRL) drv_q <= pwdata[7:0];
         wcnt  <= $rose(word_clk_out) ? 8'h00 : wcnt + 8'h01;
         wseen <= wseen | $rose(word_clk_out);
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_drv_wr;
      acc && pwrite && idx == `SOFC_IDX_DRV_CTRL;
   endsequence
   // the link clock synchroniser allows one cycle of slack
   sequence s_bit_high;
      bit_clk_out [*3];
   endsequence
   AST_FMT_RDBK: assert property (rd && idx == `SOFC_IDX_FMT_RDBK |-> prdata[7:0] == fmt_q)
      else $error("format readback wrong");
   AST_DRV_RDBK: assert property (rd && idx == `SOFC_IDX_DRV_RDBK |-> prdata[7:0] == drv_q)
      else $error("driver readback wrong");
   AST_SLVS: assert property (s_drv_wr |-> ##2 slvs_select == drv_q[0])
      else $error("standard select wrong");
   AST_CM: assert property (s_drv_wr |-> ##2 common_mode_select == (drv_q[1] && !drv_q[0]))
      else $error("common mode wrong");
   AST_CUR: assert property (s_drv_wr |-> ##2
      drive_current == ((drv_q[3:2] == `SOFC_CUR_RSVD) ? `SOFC_CUR_2MA5 : drv_q[3:2]))
      else $error("drive current wrong");
   AST_TERM: assert property (s_drv_wr |-> ##2 termination_on == drv_q[4])
      else $error("termination wrong");
   AST_BCLK: assert property ($rose(bit_clk_out) |-> s_bit_high ##[1:3] !bit_clk_out)
      else $error("bit clock high time wrong");
   AST_WCLK: assert property ($rose(word_clk_out) && wseen |-> wcnt >= 8'h5e && wcnt <= 8'h60)
      else $error("word clock period wrong");
endmodule // sofc_top_asserts
bind sofc_top sofc_top_asserts u_asserts (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .bit_clk_out, .word_clk_out, .slvs_select, .common_mode_select, .drive_current,
   .termination_on);
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for sofc_top with the link capture model
// assumes the checker and capture model are compiled before it
`timescale 1ns/1ps
`include "sofc_defs.vh"
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
// ==========================================================
// bench
module testbench;
   localparam logic [7:0] PLO = `SOFC_IDX_PAT_LO << 2;
   localparam logic [7:0] PHI = `SOFC_IDX_PAT_HI << 2;
   localparam logic [7:0] FMT = `SOFC_IDX_FMT_CTRL << 2;
   localparam logic [7:0] FRB = `SOFC_IDX_FMT_RDBK << 2;
   localparam logic [7:0] DRV = `SOFC_IDX_DRV_CTRL << 2;
   localparam logic [7:0] DRB = `SOFC_IDX_DRV_RDBK << 2;
   localparam logic [7:0] STA = `SOFC_IDX_STATUS << 2;
   logic        ref_clk, arst_n, psel, penable, pwrite, sample_valid, link_bit_clk, err;
   logic [7:0]  paddr, v, fmt;
   logic [31:0] pwdata, rd;
   logic [11:0] sample_data, got, w, x, q[$];
   wire  [31:0] prdata;
   wire  [11:0] cap_word;
   wire  [1:0]  drive_current;
   wire         pready, pslverr, sample_ready, ser_data, bit_clk_out, word_clk_out, cap_valid;
   wire         equalizer_on, slvs_select, common_mode_select, termination_on;
   int          n_fail, cmp_count, seed, i, k, n;
   sofc_top dut (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sample_data, .sample_valid, .sample_ready, .link_bit_clk, .ser_data, .bit_clk_out, .word_clk_out,
      .equalizer_on, .slvs_select, .common_mode_select, .drive_current, .termination_on);
   sofc_capture cap (.ref_clk, .arst_n, .bit_clk(bit_clk_out), .word_clk(word_clk_out), .ser_data,
      .word_bits(cap_word), .word_valid(cap_valid));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // link clock runs free, phase unrelated to ref_clk
   initial begin
      link_bit_clk = 1'b0;
      #37;
      forever #100 link_bit_clk = ~link_bit_clk;
   end
   task automatic final_report(input bit hung);
      if (hung) n_fail++;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (t = 0; t < 16; t++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (t == 16) final_report(1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic next_word(output logic [11:0] r);
      int t;
      for (t = 0; t < 400; t++) begin
         @(posedge ref_clk);
         if (cap_valid === 1'b1) break;
      end
      if (t == 400) final_report(1);
      r = cap_word;
   endtask
   function automatic logic [11:0] order(input logic [11:0] a, input logic msb);
      for (int j = 0; j < 12; j++) order[j] = msb ? a[11-j] : a[j];
   endfunction
   initial begin
      #2000000;
      final_report(1);
   end
   initial begin
      seed = 91112;
      {psel, penable, pwrite, sample_valid} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sample_data = 12'h000;
      n_fail = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      apb(0, FRB, 0);
      `CHK(rd[7:0], 8'h00)
      apb(0, DRB, 0);
      `CHK(rd[7:0], 8'h00)
      apb(0, FMT, 0);
      `CHK(rd[7:0], 8'h00)
      apb(0, 8'h7c, 0);
      `CHK(err, 1'b1)
      for (i = 0; i < 8; i++) begin
         v = 8'($random(seed)) & 8'h1f;
         v[1] = i[0];
         if (v[3:2] == `SOFC_CUR_RSVD) v[2] = 1'b1;
         apb(1, DRV, {24'h0, v});
         repeat (2) @(posedge ref_clk);
         `CHK({termination_on, drive_current}, v[4:2])
         `CHK({common_mode_select, slvs_select}, {v[1] & ~v[0], v[0]})
         apb(1, DRB, 32'hff);
         apb(0, DRB, 0);
         `CHK(rd[7:0], v)
      end
      for (i = 0; i < 6; i++) begin
         w = 12'($random(seed));
         v = 8'($random(seed));
         apb(1, PLO, {24'h0, w[7:0]});
         apb(1, PHI, {28'h0, w[11:8]});
         fmt = {3'b000, v[4], 1'b0, 1'(i / 3), 2'(i % 3 + 1)};
         apb(1, FMT, {24'h0, fmt});
         apb(1, FRB, 32'hff);
         apb(0, FRB, 0);
         `CHK(rd[7:0], fmt)
         if (fmt[1:0] == `SOFC_PAT_STEP) w = `SOFC_WORD_STEP;
         if (fmt[1:0] == `SOFC_PAT_ALT) w = `SOFC_WORD_ALT;
         repeat (2) next_word(got);
         for (k = 0; k < 3; k++) begin
            next_word(got);
            `CHK(got, order(w, fmt[2]))
         end
         `CHK(equalizer_on, fmt[4])
      end
      for (i = 0; i < 2; i++) begin
         fmt = i ? 8'h0c : 8'h10;
         apb(1, FMT, {24'h0, fmt});
         sample_valid <= 1'b1;
         sample_data <= 12'($random(seed));
         for (n = 0; n < 64; n++) begin
            @(posedge ref_clk);
            if (sample_ready !== 1'b1) break;
            q.push_back(sample_data);
            sample_data <= 12'($random(seed));
         end
         sample_valid <= 1'b0;
         `CHK(q.size() >= 32, 1'b1)
         x = order({q[0][11] ^ fmt[3], q[0][10:0]}, fmt[2]);
         for (k = 0; k < 6; k++) begin
            next_word(got);
            if (got === x) break;
         end
         `CHK(k < 6, 1'b1)
         void'(q.pop_front());
         while (q.size() > 0) begin
            next_word(got);
            x = q.pop_front();
            `CHK(got, order({x[11] ^ fmt[3], x[10:0]}, fmt[2]))
         end
         `CHK(equalizer_on, fmt[4])
      end
      apb(0, STA, 0);
      `CHK(rd[6:1], 6'h00)
      final_report(0);
   end
endmodule // testbench
`default_nettype wire
